// ===== include/spifd_defines.vh
// Purpose: constants for the spi fifo status and dma control block
// Assumes: byte addresses on a 32-bit avalon-mm slave, 16-bit registers in low lanes
// Notes: definitions only
`ifndef SPIFD_DEFINES_VH
`define SPIFD_DEFINES_VH

// register byte offsets
`define SPIFD_OFS_RX_DATA 5'h00
`define SPIFD_OFS_TX_DATA 5'h04
`define SPIFD_OFS_CONFIG 5'h08
`define SPIFD_OFS_STATUS 5'h0c
`define SPIFD_OFS_DMA 5'h14

// reset values
`define SPIFD_RST_STATUS 16'h0040
`define SPIFD_RST_DMA 16'h0000
`define SPIFD_RST_CONFIG 16'h0000

// status register fields
`define SPIFD_ST_TX_IRQ_HI 15
`define SPIFD_ST_TX_IRQ_LO 14
`define SPIFD_ST_TX_DEPTH_HI 13
`define SPIFD_ST_TX_DEPTH_LO 10
`define SPIFD_ST_TX_NOT_EMPTY 9
`define SPIFD_ST_TX_FULL 8
`define SPIFD_ST_TX_UNDERFLOW 7
`define SPIFD_ST_TX_EMPTY 6
`define SPIFD_ST_RX_OVERFLOW 5
`define SPIFD_ST_RX_FULL 4
`define SPIFD_ST_RX_NOT_EMPTY 3
`define SPIFD_ST_CONFLICT 2
`define SPIFD_ST_FLUSH 0

// dma register fields
`define SPIFD_DM_RX_EN 7
`define SPIFD_DM_TX_EN 6
`define SPIFD_DM_RX_BURST_HI 5
`define SPIFD_DM_RX_BURST_LO 4
`define SPIFD_DM_TX_BURST_HI 3
`define SPIFD_DM_TX_BURST_LO 2
`define SPIFD_DM_IF_EN 1
`define SPIFD_DM_SEL_MASK 0

// config register fields
`define SPIFD_CF_RX_DEPTH_HI 15
`define SPIFD_CF_RX_DEPTH_LO 12
`define SPIFD_CF_WSIZE_HI 11
`define SPIFD_CF_WSIZE_LO 10
`define SPIFD_CF_CLOCK_PHASE 9
`define SPIFD_CF_CONFLICT_IE 7
`define SPIFD_CF_RX_ERR_IE 4
`define SPIFD_CF_RX_IRQ_HI 3
`define SPIFD_CF_RX_IRQ_LO 2
`define SPIFD_CF_MASTER 1

// interrupt source codes and word size codes
`define SPIFD_IRQ_OFF 2'h0
`define SPIFD_IRQ_EMPTY 2'h1
`define SPIFD_IRQ_UNDER 2'h2
`define SPIFD_IRQ_FULL 2'h3
`define SPIFD_WS_16 2'h1

`endif

// ===== rtl/spifd_ctrl.v
// Purpose: fifo status, fifo depth, interrupt select and dma request logic of a buffered spi port
// Assumes: shift engine on clk supplies load and receive strobes; link pins are asynchronous
// Notes: registers reached over avalon-mm with waitrequest, one wait cycle per access
//
// Added by the designer: the Avalon-MM slave port.
`include "spifd_defines.vh"

module spifd_ctrl #(
    parameter AW = 5, // byte address width
    parameter DEPTH = 16 // largest fifo depth
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // avalon-mm slave
    input wire [AW-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // shift engine side
    input wire tx_load_req,
    output reg [15:0] tx_word,
    output reg tx_word_valid,
    input wire rx_push,
    input wire [15:0] rx_push_data,
    // link pins
    input wire sck_pin,
    input wire ss_n_pin,
    // dma and interrupt
    output reg rx_dma_req,
    output reg tx_dma_req,
    output reg irq
);

    // configuration registers
    reg [1:0] tx_irq_select_q;
    reg [3:0] tx_depth_code_q;
    reg [3:0] rx_depth_code_q;
    reg [1:0] word_size_q;
    reg clock_phase_q;
    reg master_select_q;
    reg conflict_irq_enable_q;
    reg rx_err_irq_enable_q;
    reg [1:0] rx_irq_select_q;
    reg rx_dma_req_enable_q;
    reg tx_dma_req_enable_q;
    reg [1:0] rx_burst_size_q;
    reg [1:0] tx_burst_size_q;
    reg dma_if_enable_q;
    reg select_mask_q;
    reg fifo_flush_q; // one-cycle flush pulse

    // status flags
    reg tx_underflow_flag_q;
    reg tx_empty_flag_q;
    reg rx_overflow_flag_q;
    reg bus_conflict_flag_q;
    reg under_pend_q; // underflow seen, waiting for link moment
    reg ovf_csr_seen_q; // status read since overflow
    reg ovf_fifo_seen_q; // fifo read since overflow

    // fifo storage and pointers
    reg [15:0] tx_mem [0:DEPTH-1];
    reg [15:0] rx_mem [0:DEPTH-1];
    reg [3:0] tx_wp_q;
    reg [3:0] tx_rp_q;
    reg [4:0] tx_cnt_q;
    reg [3:0] rx_wp_q;
    reg [3:0] rx_rp_q;
    reg [4:0] rx_cnt_q;

    // link synchronisers
    reg [2:0] sck_s_q;
    reg [2:0] ss_s_q;
    reg ss_eff_prev_q;

    // bus decode
    wire bus_req = avs_read | avs_write;
    wire bus_done = bus_req & ~avs_waitrequest; // access completes this edge
    wire wr_done = bus_done & avs_write;
    wire rd_take = avs_read & avs_waitrequest; // read data latched at this edge
    wire sel_rx = (avs_address == `SPIFD_OFS_RX_DATA);
    wire sel_tx = (avs_address == `SPIFD_OFS_TX_DATA);
    wire sel_cf = (avs_address == `SPIFD_OFS_CONFIG);
    wire sel_st = (avs_address == `SPIFD_OFS_STATUS);
    wire sel_dm = (avs_address == `SPIFD_OFS_DMA);
    wire [15:0] wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // depths and fill levels
    wire [4:0] tx_depth = {1'b0, tx_depth_code_q} + 5'h01;
    wire [4:0] rx_depth = {1'b0, rx_depth_code_q} + 5'h01;
    wire tx_full = (tx_cnt_q == tx_depth);
    wire tx_not_empty = (tx_cnt_q != 5'h00);
    wire rx_full = (rx_cnt_q == rx_depth);
    wire rx_not_empty = (rx_cnt_q != 5'h00);
    wire [4:0] tx_free = (tx_cnt_q > tx_depth) ? 5'h00 : (tx_depth - tx_cnt_q);
    wire wide_word = (word_size_q == `SPIFD_WS_16);

    // fifo moves
    wire tx_push = wr_done & sel_tx & ~tx_full; // writes into a full fifo are dropped
    wire tx_pop = tx_load_req & tx_not_empty;
    // pop on the edge that latches the word, so a late push is never lost
    wire rx_pop = rd_take & sel_rx & rx_not_empty;
    wire rx_take = rx_push & (~rx_full | rx_pop); // a pop frees room in the same cycle
    wire rx_lost = rx_push & rx_full & ~rx_pop;

    // link events
    wire ss_eff = select_mask_q | ss_s_q[1];
    wire ss_fall = ss_eff_prev_q & ~ss_eff;
    wire sck_edge = sck_s_q[1] ^ sck_s_q[2];
    wire under_moment = clock_phase_q ? sck_edge : ss_fall;

    // burst size decode
    function [4:0] burst_words;
        input [1:0] code;
        begin
            case (code)
                2'h0: burst_words = 5'h01;
                2'h1: burst_words = 5'h04;
                2'h2: burst_words = 5'h08;
                default: burst_words = 5'h10;
            endcase
        end
    endfunction

    // byte-lane merge for register writes
    function [15:0] merge;
        input [15:0] old;
        input [15:0] nw;
        input [15:0] m;
        begin
            merge = (old & ~m) | (nw & m);
        end
    endfunction

    wire [4:0] rx_burst = burst_words(rx_burst_size_q);
    wire [4:0] tx_burst = burst_words(tx_burst_size_q);

    // assembled register images
    wire [15:0] status_img = {tx_irq_select_q, tx_depth_code_q, tx_not_empty, tx_full,
        tx_underflow_flag_q, tx_empty_flag_q, rx_overflow_flag_q, rx_full,
        rx_not_empty, bus_conflict_flag_q, 1'b0, fifo_flush_q};
    wire [15:0] config_img = {rx_depth_code_q, word_size_q, clock_phase_q, 1'b0,
        conflict_irq_enable_q, 2'h0, rx_err_irq_enable_q, rx_irq_select_q,
        master_select_q, 1'b0};
    wire [15:0] dma_img = {8'h00, rx_dma_req_enable_q, tx_dma_req_enable_q,
        rx_burst_size_q, tx_burst_size_q, dma_if_enable_q, select_mask_q};
    wire [15:0] rx_head = rx_mem[rx_rp_q];
    wire [15:0] rx_view = wide_word ? rx_head : {rx_head[7:0], rx_head[7:0]};
    wire [15:0] st_w = merge(status_img, avs_writedata[15:0], wmask);
    wire [15:0] cf_w = merge(config_img, avs_writedata[15:0], wmask);
    wire [15:0] dm_w = merge(dma_img, avs_writedata[15:0], wmask);

    // read data mux, unmapped reads return zero
    reg [15:0] rd_mux;
    always @* begin
        if (sel_rx) begin
            rd_mux = rx_not_empty ? rx_view : 16'h0000;
        end else if (sel_cf) begin
            rd_mux = config_img;
        end else if (sel_st) begin
            rd_mux = status_img;
        end else if (sel_dm) begin
            rd_mux = dma_img;
        end else begin
            rd_mux = 16'h0000;
        end
    end

    // avalon handshake: one wait cycle, then completion
    always @(posedge clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else if (bus_req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0; // answer in the next cycle
            avs_readdata <= {16'h0000, rd_mux};
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // link pin synchronisers and select history
    always @(posedge clk) begin
        if (rst) begin
            sck_s_q <= 3'h0;
            ss_s_q <= 3'h7;
            ss_eff_prev_q <= 1'b1;
        end else begin
            sck_s_q <= {sck_s_q[1:0], sck_pin};
            ss_s_q <= {ss_s_q[1:0], ss_n_pin};
            ss_eff_prev_q <= ss_eff;
        end
    end

    // configuration register writes
    always @(posedge clk) begin
        if (rst) begin
            tx_irq_select_q <= 2'h0;
            tx_depth_code_q <= 4'h0;
            rx_depth_code_q <= 4'h0;
            word_size_q <= 2'h0;
            clock_phase_q <= 1'b0;
            master_select_q <= 1'b0;
            conflict_irq_enable_q <= 1'b0;
            rx_err_irq_enable_q <= 1'b0;
            rx_irq_select_q <= 2'h0;
            rx_dma_req_enable_q <= 1'b0;
            tx_dma_req_enable_q <= 1'b0;
            rx_burst_size_q <= 2'h0;
            tx_burst_size_q <= 2'h0;
            dma_if_enable_q <= 1'b0;
            select_mask_q <= 1'b0;
            fifo_flush_q <= 1'b0;
        end else begin
            // flush request lasts one cycle only
            fifo_flush_q <= wr_done & sel_st & avs_byteenable[0] & avs_writedata[0];
            if (wr_done && sel_st) begin
                tx_irq_select_q <= st_w[15:14];
                tx_depth_code_q <= st_w[13:10];
            end
            if (wr_done && sel_cf) begin
                rx_depth_code_q <= cf_w[15:12];
                word_size_q <= cf_w[11:10];
                clock_phase_q <= cf_w[9];
                conflict_irq_enable_q <= cf_w[7];
                rx_err_irq_enable_q <= cf_w[4];
                rx_irq_select_q <= cf_w[3:2];
                master_select_q <= cf_w[1];
            end
            if (wr_done && sel_dm) begin
                rx_dma_req_enable_q <= dm_w[7];
                tx_dma_req_enable_q <= dm_w[6];
                rx_burst_size_q <= dm_w[5:4];
                tx_burst_size_q <= dm_w[3:2];
                dma_if_enable_q <= dm_w[1];
                select_mask_q <= dm_w[0];
            end
            if (fifo_flush_q) begin
                rx_depth_code_q <= 4'h0;
            end
        end
    end

    // fifo storage writes
    always @(posedge clk) begin
        if (tx_push) begin
            tx_mem[tx_wp_q] <= avs_writedata[15:0];
        end
        if (rx_take) begin
            rx_mem[rx_wp_q] <= rx_push_data;
        end
    end

    // fifo pointers and counts, wrapping at the enabled depth
    always @(posedge clk) begin
        if (rst || fifo_flush_q) begin
            tx_wp_q <= 4'h0;
            tx_rp_q <= 4'h0;
            tx_cnt_q <= 5'h00;
            rx_wp_q <= 4'h0;
            rx_rp_q <= 4'h0;
            rx_cnt_q <= 5'h00;
        end else begin
            if (tx_push) begin
                tx_wp_q <= (tx_wp_q == tx_depth_code_q) ? 4'h0 : tx_wp_q + 4'h1;
            end
            if (tx_pop) begin
                tx_rp_q <= (tx_rp_q == tx_depth_code_q) ? 4'h0 : tx_rp_q + 4'h1;
            end
            tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
            if (rx_take) begin
                rx_wp_q <= (rx_wp_q == rx_depth_code_q) ? 4'h0 : rx_wp_q + 4'h1;
            end
            if (rx_pop) begin
                rx_rp_q <= (rx_rp_q == rx_depth_code_q) ? 4'h0 : rx_rp_q + 4'h1;
            end
            rx_cnt_q <= rx_cnt_q + {4'h0, rx_take} - {4'h0, rx_pop};
        end
    end

    // word handed to the shift engine
    always @(posedge clk) begin
        if (rst) begin
            tx_word <= 16'h0000;
            tx_word_valid <= 1'b0;
        end else begin
            tx_word_valid <= tx_pop;
            if (tx_pop) begin
                tx_word <= tx_mem[tx_rp_q];
            end
        end
    end

    // transmit status flags
    always @(posedge clk) begin
        if (rst) begin
            tx_empty_flag_q <= 1'b1;
            tx_underflow_flag_q <= 1'b0;
            under_pend_q <= 1'b0;
        end else begin
            // empty when the last word leaves, cleared by a new word
            if (fifo_flush_q || (tx_pop && tx_cnt_q == 5'h01 && !tx_push)) begin
                tx_empty_flag_q <= 1'b1;
            end else if (tx_push) begin
                tx_empty_flag_q <= 1'b0;
            end
            // load wanted with nothing stored, master only
            if (!master_select_q) begin
                under_pend_q <= 1'b0;
            end else if (tx_load_req && !tx_not_empty) begin
                under_pend_q <= 1'b1;
            end else if (under_moment) begin
                under_pend_q <= 1'b0;
            end
            // set wins over the clear by a status read
            if (under_pend_q && under_moment && master_select_q) begin
                tx_underflow_flag_q <= 1'b1;
            end else if (rd_take && sel_st) begin
                tx_underflow_flag_q <= 1'b0; // only a value software has seen is cleared
            end
        end
    end

    // receive overflow, cleared after both a status read and a fifo read
    always @(posedge clk) begin
        if (rst || fifo_flush_q) begin
            rx_overflow_flag_q <= 1'b0;
            ovf_csr_seen_q <= 1'b0;
            ovf_fifo_seen_q <= 1'b0;
        end else if (rx_lost) begin
            rx_overflow_flag_q <= 1'b1;
            ovf_csr_seen_q <= 1'b0;
            ovf_fifo_seen_q <= 1'b0;
        end else if (rx_overflow_flag_q) begin
            if ((ovf_csr_seen_q || (rd_take && sel_st)) &&
                (ovf_fifo_seen_q || (rd_take && sel_rx))) begin
                rx_overflow_flag_q <= 1'b0;
                ovf_csr_seen_q <= 1'b0;
                ovf_fifo_seen_q <= 1'b0;
            end else begin
                ovf_csr_seen_q <= ovf_csr_seen_q | (rd_take & sel_st);
                ovf_fifo_seen_q <= ovf_fifo_seen_q | (rd_take & sel_rx);
            end
        end
    end

    // bus conflict between two masters
    always @(posedge clk) begin
        if (rst) begin
            bus_conflict_flag_q <= 1'b0;
        end else if (master_select_q && ss_fall) begin
            bus_conflict_flag_q <= 1'b1;
        end else if (ss_eff || select_mask_q || !master_select_q) begin
            bus_conflict_flag_q <= 1'b0;
        end
    end

    // interrupt sources
    reg tx_irq_src;
    reg rx_irq_src;
    always @* begin
        case (tx_irq_select_q)
            `SPIFD_IRQ_EMPTY: tx_irq_src = tx_empty_flag_q;
            `SPIFD_IRQ_UNDER: tx_irq_src = tx_underflow_flag_q & master_select_q;
            `SPIFD_IRQ_FULL: tx_irq_src = tx_full;
            default: tx_irq_src = 1'b0;
        endcase
        case (rx_irq_select_q)
            `SPIFD_IRQ_EMPTY: rx_irq_src = rx_not_empty;
            `SPIFD_IRQ_FULL: rx_irq_src = rx_full;
            default: rx_irq_src = 1'b0;
        endcase
    end

    // merged interrupt and dma requests
    always @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
            rx_dma_req <= 1'b0;
            tx_dma_req <= 1'b0;
        end else begin
            irq <= tx_irq_src | rx_irq_src | (rx_err_irq_enable_q & rx_overflow_flag_q) |
                (conflict_irq_enable_q & bus_conflict_flag_q);
            rx_dma_req <= dma_if_enable_q & rx_dma_req_enable_q &
                (rx_cnt_q >= rx_burst);
            tx_dma_req <= dma_if_enable_q & tx_dma_req_enable_q &
                (tx_free >= tx_burst);
        end
    end

endmodule // spifd_ctrl

// ===== testbench/spifd_ctrl_monitor.sv
// Purpose: checker of the spi fifo status and dma control block
// Assumes: sees top ports only, mirrors registers from completed writes
// Notes: flags, irq and dma requests lag their cause by one cycle
module spifd_ctrl_monitor #(
    parameter AW = 5 // byte address width
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // avalon-mm slave
    input wire [AW-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // dma and interrupt
    input wire rx_dma_req,
    input wire tx_dma_req,
    input wire irq
);
    reg [15:0] cfg_q; // mirrored config
    reg [7:0] dma_q; // mirrored dma control
    reg [1:0] tsel_q; // mirrored tx irq select
    reg [2:0] quiet_q; // cycles with detection off
    wire wr_ok = avs_write && !avs_waitrequest; // write done
    wire rd_ok = avs_read && !avs_waitrequest; // read done
    wire st_rd = rd_ok && avs_address == 5'h0c; // status read
    wire quiet = dma_q[0] || !cfg_q[1]; // masked or slave
    wire ws8 = cfg_q[11:10] == 2'h0; // byte words
    wire src = cfg_q[7] || cfg_q[4] || cfg_q[3:2] != 2'h0 || tsel_q != 2'h0;
    // mirror register writes
    always @(posedge clk) begin
        if (rst) begin
            cfg_q <= 16'h0000;
            dma_q <= 8'h00;
            tsel_q <= 2'h0;
        end else if (wr_ok && avs_address == 5'h08) begin
            if (avs_byteenable[0]) cfg_q[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1]) cfg_q[15:8] <= avs_writedata[15:8];
        end else if (wr_ok && avs_address == 5'h0c && avs_byteenable[1]) begin
            tsel_q <= avs_writedata[15:14];
        end else if (wr_ok && avs_address == 5'h14 && avs_byteenable[0]) begin
            dma_q <= avs_writedata[7:0];
        end
    end
    // saturating count of quiet cycles
    always @(posedge clk) begin
        if (rst || !quiet) begin
            quiet_q <= 3'h0;
        end else if (quiet_q != 3'h7) begin
            quiet_q <= quiet_q + 3'h1;
        end
    end
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (rst);
    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered");
    wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    dma_gate_a: assert property (!dma_q[1] && !$past(dma_q[1]) |-> !rx_dma_req && !tx_dma_req)
        else $error("dma request while disabled");
    rx_gate_a: assert property (!dma_q[7] && !$past(dma_q[7]) |-> !rx_dma_req)
        else $error("rx request while off");
    tx_gate_a: assert property (!dma_q[6] && !$past(dma_q[6]) |-> !tx_dma_req)
        else $error("tx request while off");
    full_ne_a: assert property (st_rd |-> !avs_readdata[8] || avs_readdata[9])
        else $error("full without not empty");
    empty_ne_a: assert property (st_rd |-> !(avs_readdata[6] && avs_readdata[9]))
        else $error("empty and not empty");
    conflict_quiet_a: assert property (st_rd && quiet_q == 3'h7 |-> !avs_readdata[2])
        else $error("conflict while masked");
    irq_quiet_a: assert property (!src && !$past(src) |-> !irq)
        else $error("irq with no source");
    byte_dup_a: assert property (rd_ok && avs_address == 5'h00 && ws8 && $past(ws8)
        |-> avs_readdata[15:8] == avs_readdata[7:0])
        else $error("byte not replicated");
endmodule // spifd_ctrl_monitor

bind spifd_ctrl spifd_ctrl_monitor #(.AW(AW)) spifd_ctrl_monitor_inst (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req), .irq(irq));

// ===== testbench/spifd_ctrl_tb.sv
// Purpose: self-checking bench of the spi fifo status and dma control block
// Assumes: avalon-mm master tasks, peer model makes the link pins
// Notes: read data and tx words are queued and compared as they appear
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %0t got %h want %h", $time, g, e); end end
module spifd_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk; // bench clock
    logic rst = 1'h1; // held five cycles
    logic [4:0] avs_address = 5'h00; // bus request
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic tx_load_req = 1'h0; // shift engine strobes
    logic rx_push = 1'h0;
    logic [15:0] rx_push_data = 16'h0;
    logic frame = 1'h0; // peer frame command
    wire [31:0] avs_readdata;
    wire [15:0] tx_word;
    wire avs_waitrequest, tx_word_valid, sck_pin, ss_n_pin, rx_dma_req, tx_dma_req, irq;
    int fail_count = 0;
    int checked = 0;
    logic [31:0] seed = 32'ha3a4; // xorshift state
    logic [15:0] exp_q[$], msk_q[$], tx_q[$], rx_q[$]; // expectations
    logic [15:0] w, we, wm, wt; // scratch, wt owned by the tx compare
    spifd_ctrl spifd_ctrl_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tx_load_req(tx_load_req), .tx_word(tx_word),
        .tx_word_valid(tx_word_valid), .rx_push(rx_push), .rx_push_data(rx_push_data),
        .sck_pin(sck_pin), .ss_n_pin(ss_n_pin), .rx_dma_req(rx_dma_req),
        .tx_dma_req(tx_dma_req), .irq(irq));
    spifd_peer spifd_peer_inst (.frame(frame), .sck_pin(sck_pin), .ss_n_pin(ss_n_pin));
    // 100 mhz clock
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    function automatic logic [15:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction
    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic [4:0] a, input logic wr, input logic [15:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= 4'hf;
        do @(posedge clk); while (avs_waitrequest !== 1'h0);
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        bus(a, 1'h1, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(a, 1'h0, 16'h0000);
    endtask
    task automatic settle;
        repeat (24) @(posedge clk);
    endtask
    // received words, kept as expected unless dropped
    task automatic rxp(input int n, input logic k);
        repeat (n) begin
            @(posedge clk);
            w = xs();
            rx_push <= 1'h1;
            rx_push_data <= w;
            if (k) rx_q.push_back(w);
            @(posedge clk);
            rx_push <= 1'h0;
        end
    endtask
    // shift engine asks for words
    task automatic pop(input int n);
        repeat (n) begin
            @(posedge clk);
            tx_load_req <= 1'h1;
            @(posedge clk);
            tx_load_req <= 1'h0;
            @(posedge clk);
        end
    endtask
    // compare read data as each read completes
    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'h0) begin
            wm = msk_q.pop_front();
            we = exp_q.pop_front();
            `CHK(avs_readdata[15:0] & wm, we & wm)
        end
    end
    // compare tx words in fifo order
    always @(posedge clk) begin
        if (tx_word_valid === 1'h1) begin
            wt = tx_q.pop_front();
            `CHK(tx_word, wt)
        end
    end
    task automatic test_done;
        if (fail_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #100000;
        fail_count++;
        test_done;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        rd(5'h0c, 16'h0040, 16'hffff);
        rd(5'h14, 16'h0000, 16'hffff);
        rd(5'h08, 16'h0000, 16'hffff);
        rd(5'h1c, 16'h0000, 16'hffff);
        // four-word tx fifo, full source, fifth word refused
        wr(5'h0c, 16'hcc00);
        for (int i = 0; i < 5; i++) begin
            w = xs();
            if (i < 4) tx_q.push_back(w);
            wr(5'h04, w);
            rd(5'h0c, (i >= 3) ? 16'h0300 : 16'h0200, 16'h0340);
        end
        settle;
        `CHK(irq, 1'h1)
        wr(5'h0c, 16'h4c00);
        settle;
        `CHK(irq, 1'h0)
        pop(4);
        rd(5'h0c, 16'h0040, 16'h0340);
        settle;
        `CHK(irq, 1'h1)
        // tx dma with a sixteen-word fifo, burst of four
        wr(5'h0c, 16'h3c00);
        wr(5'h14, 16'h0044);
        settle;
        `CHK(tx_dma_req, 1'h0)
        wr(5'h14, 16'h0046);
        settle;
        `CHK(tx_dma_req, 1'h1)
        repeat (12) wr(5'h04, xs());
        settle;
        `CHK(tx_dma_req, 1'h1)
        wr(5'h04, xs());
        settle;
        `CHK(tx_dma_req, 1'h0)
        // flush empties fifos and drops rx depth
        wr(5'h08, 16'h3000);
        wr(5'h0c, 16'h0001);
        rd(5'h0c, 16'h0040, 16'h0341);
        rd(5'h08, 16'h0000, 16'hf000);
        // four-word rx fifo, not-empty source, burst of four
        wr(5'h08, 16'h3414);
        wr(5'h14, 16'h0092);
        rxp(1, 1'h1);
        settle;
        `CHK(irq, 1'h1)
        `CHK(rx_dma_req, 1'h0)
        rd(5'h0c, 16'h0008, 16'h0038);
        wr(5'h08, 16'h341c);
        settle;
        `CHK(irq, 1'h0)
        rxp(3, 1'h1);
        settle;
        `CHK(rx_dma_req, 1'h1)
        `CHK(irq, 1'h1)
        rd(5'h0c, 16'h0018, 16'h0038);
        rxp(1, 1'h0);
        rd(5'h0c, 16'h0038, 16'h0038);
        rd(5'h00, rx_q.pop_front(), 16'hffff);
        settle;
        `CHK(rx_dma_req, 1'h0)
        rd(5'h0c, 16'h0008, 16'h0038);
        repeat (3) rd(5'h00, rx_q.pop_front(), 16'hffff);
        rd(5'h0c, 16'h0000, 16'h0038);
        // byte words are replicated on read
        wr(5'h08, 16'h0000);
        rxp(1, 1'h1);
        w = rx_q.pop_front();
        rd(5'h00, {w[7:0], w[7:0]}, 16'hffff);
        // remote select low while master
        wr(5'h08, 16'h0082);
        frame <= 1'h1;
        settle;
        rd(5'h0c, 16'h0004, 16'h0004);
        `CHK(irq, 1'h1)
        wr(5'h14, 16'h0001);
        rd(5'h0c, 16'h0000, 16'h0004);
        wr(5'h14, 16'h0000);
        frame <= 1'h0;
        settle;
        rd(5'h0c, 16'h0000, 16'h0004);
        // underflow, clock_phase one, flagged on first sck edge
        wr(5'h14, 16'h0001);
        wr(5'h08, 16'h0202);
        wr(5'h0c, 16'h8000);
        pop(1);
        settle;
        `CHK(irq, 1'h0)
        frame <= 1'h1;
        settle;
        `CHK(irq, 1'h1)
        rd(5'h0c, 16'h0080, 16'h0080);
        rd(5'h0c, 16'h0000, 16'h0080);
        frame <= 1'h0;
        settle;
        // underflow, clock_phase zero, flagged on select fall
        wr(5'h14, 16'h0000);
        wr(5'h08, 16'h0002);
        pop(1);
        rd(5'h0c, 16'h0000, 16'h0080);
        frame <= 1'h1;
        settle;
        rd(5'h0c, 16'h0080, 16'h0080);
        frame <= 1'h0;
        settle;
        test_done;
    end
endmodule // spifd_ctrl_tb

// ===== testbench/spifd_peer.sv
// Purpose: remote spi party making the link pins
// Assumes: sck idles low, select pulled up outside frames
// Notes: sck runs at 125 ns only while the bench commands a frame
module spifd_peer (
    // frame command
    input wire logic frame,
    // link pins
    output logic sck_pin,
    output logic ss_n_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    // select low, then sck toggles until the frame ends
    initial begin
        sck_pin = 1'h0;
        ss_n_pin = 1'h1;
        forever begin
            @(posedge frame);
            ss_n_pin = 1'h0;
            while (frame) begin
                #62.5;
                sck_pin = ~sck_pin;
            end
            sck_pin = 1'h0;
            #62.5;
            ss_n_pin = 1'h1;
        end
    end
endmodule // spifd_peer
